// File: design/port_protection_defines.vh
// Constants shared by the repeater port protection logic.
`ifndef PORT_PROTECTION_DEFINES_VH
`define PORT_PROTECTION_DEFINES_VH

// Clock and bit-time periods in picoseconds.
`define MCLK_PERIOD_PS 25000
`define BIT_TIME_PS 10000

// Timer figures in bit times.
`define FALSE_CARRIER_TIMER_BT 450
`define FALSE_CARRIER_TIMER_MAX_BT 500
`define QUIET_WAIT_TIMER_BT 33000
`define IPG_TIMER_BT 96
`define VALID_CARRIER_TIMER_BT 64
`define CLEAN_ACTIVITY_TIMER_BT 512
`define LONG_RECEIVE_TIMER_BT 60000
`define PACKET_START_DELAY_BT 46

// Default quiet-wait and long-receive windows in 25 ns clock cycles.
`define IDLE_CYCLES_DEFAULT 16'h3390
`define JABBER_CYCLES_DEFAULT 16'h5dc0

// Protection limits.
`define FALSE_CARRIER_LIMIT 2'h2
`define CC_LIMIT_DEFAULT 8'h3d

// Counter geometry.
`define CNT_W 16
`define CNT_MAX 16'hffff

// Register byte addresses.
`define ADDR_W 5
`define REG_CONTROL 5'h00
`define REG_ISOLATE 5'h04
`define REG_PARTITION 5'h08
`define REG_JABBER 5'h0c
`define REG_ACTIVITY 5'h10

// Control field positions and reset value.
`define CTRL_SPEED_BLOCK 0
`define CTRL_RESET 1'h1

// Activity summation levels.
`define ACT_NONE 2'h0
`define ACT_ONE 2'h1
`define ACT_MANY 2'h2

`endif

// File: design/repeater_port_protection.v
// Per-port carrier integrity, partition, jabber and speed protection for a repeater.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "port_protection_defines.vh"

// Notes on behaviour
// - Jam ends no later than packet start delay.
// - Bad-start counter increments; valid start clears it.
// - Carrier without valid start delimiter is false.
// - False carrier timer runs only during event.
// - Jam forced until event ends or timer expires.
// - False carrier timer expires within 450..500 bit times.
// - Isolate on reset, count over limit, long event.
// - Isolated port neither forwards nor transmits; still monitors.
// - Leave isolation after gap plus quiet idle.
// - Leave isolation on long valid carrier after gap.
// - Quiet wait timer is 33000 bit times.
// - Other-speed signals can be blocked from repeating.
// - Collided transmissions count up; clean one clears.
// - Partition when collision count exceeds limit.
// - Partitioned port transmits but does not forward.
// - Partition clears on reset or clean activity.
// - Reception beyond long-receive window sets jabber.
// - Jabber blocks both forwarding and transmitting.
// - Jabber clears on reset or carrier loss.
// - Activity summed as none, one, or many.
// - After collision, drain flag follows inverted source carrier.
// - Overriding transitions take precedence over others.
// - Timers restart whenever their starting state re-enters.
module repeater_port_protection #(
   parameter N = 4,
   // Quiet-wait window in clock cycles, 33000 bit times by default.
   parameter [15:0] IDLE_CYCLES = `IDLE_CYCLES_DEFAULT,
   // Long-receive window in clock cycles.
   parameter [15:0] JABBER_CYCLES = `JABBER_CYCLES_DEFAULT,
   parameter [7:0] CC_LIMIT = `CC_LIMIT_DEFAULT
) (
   input wire mclk,
   input wire rstn,
   input wire [`ADDR_W-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire [N-1:0] carrier,
   input wire [N-1:0] bad_start,
   input wire [N-1:0] other_speed,
   input wire [N-1:0] tx_active,
   input wire [N-1:0] tx_collision,
   input wire core_collision,
   input wire [2:0] source_port,
   input wire data_sent,
   output reg [N-1:0] rx_enable,
   output reg [N-1:0] tx_enable,
   output reg [N-1:0] isolated,
   output reg [N-1:0] partitioned,
   output reg [N-1:0] jabber,
   output reg force_jam,
   output reg [1:0] activity_level,
   output reg jam_request,
   output reg all_data_sent
);

   ////////////////////////////////////////////////////////////////////////////////
   // Timing constants.

   // Converts bit times to clock cycles, rounding up, never below one.
   function [15:0] ceil_cycles;
      input integer bt;
      integer c;
      begin
         c = (bt * `BIT_TIME_PS + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS;
         if (c < 1) begin
            c = 1;
         end
         ceil_cycles = c[15:0];
      end
   endfunction

   // Counts the set bits of a port vector, saturating at two.
   function [1:0] level_of;
      input [N-1:0] v;
      integer k;
      reg [7:0] c;
      begin
         c = 8'h00;
         for (k = 0; k < N; k = k + 1) begin
            c = c + {7'h00, v[k]};
         end
         if (c == 8'h00) begin
            level_of = `ACT_NONE;
         end else if (c == 8'h01) begin
            level_of = `ACT_ONE;
         end else begin
            level_of = `ACT_MANY;
         end
      end
   endfunction

   // Cycle counts of each timer, rounded up to whole clocks so no timer runs short.
   localparam [15:0] FC_CYCLES = ceil_cycles(`FALSE_CARRIER_TIMER_BT);
   localparam [15:0] IPG_CYCLES = ceil_cycles(`IPG_TIMER_BT);
   localparam [15:0] VALID_CYCLES = ceil_cycles(`VALID_CARRIER_TIMER_BT);
   localparam [15:0] CLEAN_CYCLES = ceil_cycles(`CLEAN_ACTIVITY_TIMER_BT);
   localparam [15:0] QUIET_CYCLES = IPG_CYCLES + IDLE_CYCLES;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release.

   reg rst_meta;
   reg rst_n;

   // Releases the asynchronous reset through two flip-flops.
   // Only the second flip-flop feeds the logic, so a late release cannot upset it.
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-port state.

   // Registered per-port state.
   reg [N-1:0] carrier_d;
   reg [N-1:0] tx_active_d;
   reg [N-1:0] fc_active;
   reg [N-1:0] good_event;
   reg [N-1:0] quiet_before;
   reg [N-1:0] tx_collided;
   reg [N-1:0] iso;
   reg [N-1:0] part;
   reg [N-1:0] jab;
   reg [1:0] fc_count [0:N-1];
   reg [7:0] cc_count [0:N-1];
   reg [`CNT_W-1:0] fc_timer [0:N-1];
   reg [`CNT_W-1:0] idle_cnt [0:N-1];
   reg [`CNT_W-1:0] good_cnt [0:N-1];
   reg [`CNT_W-1:0] rx_cnt [0:N-1];
   reg [`CNT_W-1:0] clean_cnt [0:N-1];
   reg speed_block;
   reg collision_seen;

   // Per-port decode of the current inputs and state.
   reg [N-1:0] start_ev;
   reg [N-1:0] fc_done;
   reg [N-1:0] clean_done;
   reg [N-1:0] tx_end;
   reg [N-1:0] jam_port;
   reg [N-1:0] rx_ok;
   reg [N-1:0] active;
   reg src_carrier;
   integer j;

   // Decodes edges, timer completions and per-port permissions.
   always @* begin
      src_carrier = 1'b0;
      for (j = 0; j < N; j = j + 1) begin
         start_ev[j] = carrier[j] & ~carrier_d[j];
         fc_done[j] = (fc_timer[j] >= FC_CYCLES);
         clean_done[j] = (clean_cnt[j] > CLEAN_CYCLES);
         tx_end[j] = tx_active_d[j] & ~tx_active[j];
         // An isolated port raises no jam, as nothing of it reaches the core.
         jam_port[j] = fc_active[j] & ~fc_done[j] & ~iso[j];
         rx_ok[j] = ~iso[j] & ~part[j] & ~jab[j] & ~(speed_block & other_speed[j]);
         active[j] = carrier[j] & rx_ok[j];
         if (source_port == j[2:0]) begin
            src_carrier = carrier[j];
         end
      end
   end

   // Loop index over the per-port registers.
   integer i;

   // Runs every port's carrier, isolation, partition and jabber machinery.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         carrier_d <= {N{1'b0}};
         tx_active_d <= {N{1'b0}};
         fc_active <= {N{1'b0}};
         good_event <= {N{1'b0}};
         quiet_before <= {N{1'b0}};
         tx_collided <= {N{1'b0}};
         iso <= {N{1'b1}};
         part <= {N{1'b0}};
         jab <= {N{1'b0}};
         for (i = 0; i < N; i = i + 1) begin
            fc_count[i] <= 2'h0;
            cc_count[i] <= 8'h00;
            fc_timer[i] <= {`CNT_W{1'b0}};
            idle_cnt[i] <= {`CNT_W{1'b0}};
            good_cnt[i] <= {`CNT_W{1'b0}};
            rx_cnt[i] <= {`CNT_W{1'b0}};
            clean_cnt[i] <= {`CNT_W{1'b0}};
         end
      end else begin
         // Delayed copies mark the start of carrier and the end of a transmission.
         carrier_d <= carrier;
         tx_active_d <= tx_active;
         for (i = 0; i < N; i = i + 1) begin
            // False carrier timer restarts on every new bad start.
            if (start_ev[i] && bad_start[i]) begin
               fc_active[i] <= 1'b1;
               fc_timer[i] <= {`CNT_W{1'b0}};
            end else if (!carrier[i]) begin
               fc_active[i] <= 1'b0;
               fc_timer[i] <= {`CNT_W{1'b0}};
            end else if (fc_active[i] && !fc_done[i]) begin
               fc_timer[i] <= fc_timer[i] + 16'h0001;
            end
            // Consecutive false carrier count, saturating.
            if (start_ev[i] && bad_start[i]) begin
               if (fc_count[i] != 2'h3) begin
                  fc_count[i] <= fc_count[i] + 2'h1;
               end
            end else if (start_ev[i]) begin
               fc_count[i] <= 2'h0;
            end
            // Idle length and the quiet gap seen before each event.
            if (carrier[i]) begin
               idle_cnt[i] <= {`CNT_W{1'b0}};
            end else if (idle_cnt[i] != `CNT_MAX) begin
               idle_cnt[i] <= idle_cnt[i] + 16'h0001;
            end
            if (start_ev[i]) begin
               good_event[i] <= ~bad_start[i];
               quiet_before[i] <= (idle_cnt[i] > IPG_CYCLES);
               good_cnt[i] <= {`CNT_W{1'b0}};
            end else if (carrier[i] && good_cnt[i] != `CNT_MAX) begin
               good_cnt[i] <= good_cnt[i] + 16'h0001;
            end
            // Entering isolation overrides any exit condition.
            // A long valid event after a gap ends isolation before the quiet wait.
            if ((start_ev[i] && bad_start[i] && fc_count[i] >= `FALSE_CARRIER_LIMIT) ||
                (fc_active[i] && fc_done[i] && carrier[i])) begin
               iso[i] <= 1'b1;
            end else if (idle_cnt[i] > QUIET_CYCLES) begin
               iso[i] <= 1'b0;
            end else if (carrier[i] && good_event[i] && quiet_before[i] && good_cnt[i] > VALID_CYCLES) begin
               iso[i] <= 1'b0;
            end
            // Receive length window and jabber.
            if (!carrier[i]) begin
               rx_cnt[i] <= {`CNT_W{1'b0}};
               jab[i] <= 1'b0;
            end else begin
               if (rx_cnt[i] != `CNT_MAX) begin
                  rx_cnt[i] <= rx_cnt[i] + 16'h0001;
               end
               if (rx_cnt[i] > JABBER_CYCLES) begin
                  jab[i] <= 1'b1;
               end
            end
            // Collision marking within one transmission.
            if (tx_active[i] && !tx_active_d[i]) begin
               tx_collided[i] <= tx_collision[i];
            end else if (tx_active[i] && tx_collision[i]) begin
               tx_collided[i] <= 1'b1;
            end
            // Consecutive collision count, cleared by clean activity.
            if (clean_done[i]) begin
               cc_count[i] <= 8'h00;
            end else if (tx_end[i]) begin
               if (tx_collided[i] || tx_collision[i]) begin
                  if (cc_count[i] != 8'hff) begin
                     cc_count[i] <= cc_count[i] + 8'h01;
                  end
               end else begin
                  cc_count[i] <= 8'h00;
               end
            end
            // Clean activity timer restarts on any collision or quiet.
            if (tx_collision[i] || (!carrier[i] && !tx_active[i])) begin
               clean_cnt[i] <= {`CNT_W{1'b0}};
            end else if (clean_cnt[i] != `CNT_MAX) begin
               clean_cnt[i] <= clean_cnt[i] + 16'h0001;
            end
            // Partition sets past the limit unless clean activity clears it now.
            if (cc_count[i] > CC_LIMIT && !clean_done[i]) begin
               part[i] <= 1'b1;
            end else if (clean_done[i]) begin
               part[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Core-facing outputs.

   // Registers port permissions, activity summation and drain flag.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_enable <= {N{1'b0}};
         tx_enable <= {N{1'b0}};
         isolated <= {N{1'b1}};
         partitioned <= {N{1'b0}};
         jabber <= {N{1'b0}};
         force_jam <= 1'b0;
         activity_level <= `ACT_NONE;
         jam_request <= 1'b0;
         collision_seen <= 1'b0;
         all_data_sent <= 1'b0;
      end else begin
         // Permissions and status mirror the internal state one cycle later.
         rx_enable <= rx_ok;
         tx_enable <= ~iso & ~jab;
         isolated <= iso;
         partitioned <= part;
         jabber <= jab;
         force_jam <= |jam_port;
         // A false carrier on any port that is not isolated reads as several active ports.
         if (|jam_port) begin
            activity_level <= `ACT_MANY;
         end else begin
            activity_level <= level_of(active);
         end
         // At most two cycles from the end condition to jam release, well inside the start delay.
         jam_request <= (|jam_port) | (level_of(active) == `ACT_MANY);
         // Remembers a collision until every receive-enabled port has fallen quiet and no port raises a false carrier jam.
         if (core_collision) begin
            collision_seen <= 1'b1;
         end else if (level_of(active) == `ACT_NONE && !(|jam_port)) begin
            collision_seen <= 1'b0;
         end
         // A source index beyond the ports reads as no carrier.
         if (core_collision || collision_seen) begin
            all_data_sent <= ~src_carrier;
         end else begin
            all_data_sent <= data_sent;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register port.

   // Holds the speed blocking control.
   // Blocking is on from reset, so other-speed signals never slip through early.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         speed_block <= `CTRL_RESET;
      end else if (wr && addr == `REG_CONTROL) begin
         speed_block <= wdata[`CTRL_SPEED_BLOCK];
      end
   end

   // Returns read data in the cycle after the read strobe only.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         // Unmapped addresses read as zero.
         case (addr)
            `REG_CONTROL: rdata <= {31'h00000000, speed_block};
            `REG_ISOLATE: rdata <= {{(32-N){1'b0}}, iso};
            `REG_PARTITION: rdata <= {{(32-N){1'b0}}, part};
            `REG_JABBER: rdata <= {{(32-N){1'b0}}, jab};
            `REG_ACTIVITY: rdata <= {29'h00000000, |jam_port, activity_level};
            default: rdata <= 32'h00000000;
         endcase
      end else begin
         rdata <= 32'h00000000;
      end
   end

endmodule
`default_nettype wire

// File: verif/port_protection_props.sv
// Concurrent checks on the ports of the repeater port protection block.
`timescale 1ns/100ps
`default_nettype none
`include "port_protection_defines.vh"
module port_protection_props #(
   parameter N = 4
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [N-1:0] carrier,
   input wire logic [N-1:0] rx_enable,
   input wire logic [N-1:0] tx_enable,
   input wire logic [N-1:0] isolated,
   input wire logic [N-1:0] partitioned,
   input wire logic [N-1:0] jabber,
   input wire logic force_jam,
   input wire logic [1:0] activity_level,
   input wire logic jam_request
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic [8:0] jam_cycles;
   ////////////////////////////////////////////////////////////////////////////////
   // Counts consecutive cycles of forced jam, so a stuck timer shows up as a long run.
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         jam_cycles <= 9'h0;
      end else begin
         jam_cycles <= force_jam ? jam_cycles + 9'h1 : 9'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Three quiet cycles cover the two-cycle input to output latency.
   sequence s_quiet;
      (carrier == '0) [*3];
   endsequence
   sequence s_release;
      $rose(rstn);
   endsequence
   property p_jam_end;
      s_quiet |-> !force_jam && !jam_request;
   endproperty
   a_jam_end: assert property (p_jam_end) else $error("jam outlived carrier");
   property p_idle_level;
      s_quiet |-> activity_level == `ACT_NONE;
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("activity without carrier");
   property p_jabber_clear;
      s_quiet |-> jabber == '0;
   endproperty
   a_jabber_clear: assert property (p_jabber_clear) else $error("jabber kept after carrier loss");
   property p_iso_gate;
      (isolated & (rx_enable | tx_enable)) == '0;
   endproperty
   a_iso_gate: assert property (p_iso_gate) else $error("isolated port enabled");
   property p_jab_gate;
      (jabber & (rx_enable | tx_enable)) == '0;
   endproperty
   a_jab_gate: assert property (p_jab_gate) else $error("jabbering port enabled");
   property p_part_gate;
      (partitioned & rx_enable) == '0;
   endproperty
   a_part_gate: assert property (p_part_gate) else $error("partitioned port forwards");
   property p_fc_bound;
      jam_cycles <= 9'h0c8;
   endproperty
   a_fc_bound: assert property (p_fc_bound) else $error("false carrier jam too long");
   property p_fc_many;
      $rose(force_jam) |-> activity_level == `ACT_MANY && jam_request;
   endproperty
   a_fc_many: assert property (p_fc_many) else $error("false carrier not summed as many");
   property p_reset_iso;
      s_release |-> (isolated == '1) [*4];
   endproperty
   a_reset_iso: assert property (p_reset_iso) else $error("ports not isolated after reset");
   property p_rdata_idle;
      !$past(rd) |-> rdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule
`default_nettype wire

// File: verif/port_attach_model.sv
// Receive attachment model that plays carrier events into the protection block.
`timescale 1ns/100ps
`default_nettype none
module port_attach_model #(
   parameter N = 4
) (
   input wire logic mclk,
   input wire logic [N-1:0] go,
   input wire logic [15:0] len,
   input wire logic bad,
   output logic [N-1:0] carrier = '0,
   output logic [N-1:0] bad_start = '0
);
   logic [15:0] left [N] = '{default: 16'h0};
   // Carrier stands len cycles; the start flag toggles when it carries no meaning.
   always @(posedge mclk) begin
      bad_start <= ~bad_start;
      for (int i = 0; i < N; i++) begin
         if (go[i]) begin
            carrier[i] <= 1'b1;
            bad_start[i] <= bad;
            left[i] <= len - 16'h1;
         end else if (left[i] != 16'h0) begin
            left[i] <= left[i] - 16'h1;
         end else begin
            carrier[i] <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: verif/repeater_port_protection_bench.sv
// Self-checking bench for the repeater port protection block.
`timescale 1ns/100ps
`default_nettype none
`include "port_protection_defines.vh"
module repeater_port_protection_bench;
   logic mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, bad = 1'b0;
   logic core_collision = 1'b0, data_sent = 1'b0;
   logic [4:0] addr = 5'h0;
   logic [31:0] wdata = 32'h0, rdata, r;
   logic [3:0] go = 4'h0, other_speed = 4'h0, tx_active = 4'h0, tx_collision = 4'h0;
   logic [3:0] carrier, bad_start, rx_enable, tx_enable, isolated, partitioned, jabber;
   logic [2:0] source_port = 3'h0;
   logic [15:0] len = 16'h0;
   logic [1:0] activity_level;
   logic force_jam, jam_request, all_data_sent;
   int fail_count = 0, checks = 0, seed;
   repeater_port_protection #(.N(4), .IDLE_CYCLES(16'h32), .JABBER_CYCLES(16'h12c)) i_repeater_port_protection (
      .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .carrier(carrier), .bad_start(bad_start), .other_speed(other_speed), .tx_active(tx_active),
      .tx_collision(tx_collision), .core_collision(core_collision), .source_port(source_port),
      .data_sent(data_sent), .rx_enable(rx_enable), .tx_enable(tx_enable), .isolated(isolated),
      .partitioned(partitioned), .jabber(jabber), .force_jam(force_jam),
      .activity_level(activity_level), .jam_request(jam_request), .all_data_sent(all_data_sent));
   port_attach_model #(.N(4)) i_port_attach_model (.mclk(mclk), .go(go), .len(len), .bad(bad),
      .carrier(carrier), .bad_start(bad_start));
   ////////////////////////////////////////////////////////////////////////////////
   // Expected summation level for a set of active ports.
   function automatic logic [1:0] exp_level(input logic [3:0] m);
      return ($countones(m) > 1) ? `ACT_MANY : (m != 4'h0 ? `ACT_ONE : `ACT_NONE);
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string name);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 check(name, rdata, exp);
   endtask
   task automatic launch(input logic [3:0] m, input logic [15:0] n, input logic b);
      @(posedge mclk);
      go <= m;
      len <= n;
      bad <= b;
      @(posedge mclk);
      go <= 4'h0;
   endtask
   // Plays one event; c enables the mid-event checks on an enabled port.
   task automatic rx_event(input logic [3:0] m, input logic [15:0] n, input logic b, input logic c);
      launch(m, n, b);
      settle(4);
      if (c && b) check("force_jam", force_jam, 32'h1);
      if (c && !b) check("level", {jam_request, activity_level}, {exp_level(m) == `ACT_MANY, exp_level(m)});
      if (c && !b) check("drain", all_data_sent, core_collision ? !m[source_port] : data_sent);
      settle(n + 3);
   endtask
   task automatic xmit(input int k, input logic col);
      repeat (k) begin
         @(posedge mclk);
         tx_active <= 4'h1;
         tx_collision <= {3'h0, col};
         repeat (3) @(posedge mclk);
         tx_active <= 4'h0;
         tx_collision <= 4'h0;
         repeat (2) @(posedge mclk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard.
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      repeat (10000) @(posedge mclk);
      fail_count++;
      stop_test();
   end
   // Main sequence of scenarios.
   initial begin
      seed = 69221;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      settle(3);
      check("isolated", isolated, 32'hf);
      check("part jab", {partitioned, jabber}, 32'h0);
      rd_chk(`REG_ISOLATE, 32'hf, "isolate reg");
      wr_reg(`REG_ISOLATE, 32'h0);
      rd_chk(`REG_ISOLATE, 32'hf, "isolate ro");
      rd_chk(`REG_CONTROL, 32'h1, "control");
      rd_chk(5'h14, 32'h0, "unmapped");
      settle(100);
      check("quiet exit", {isolated, rx_enable, tx_enable}, 32'hff);
      @(posedge mclk);
      other_speed <= 4'h4;
      settle(4);
      check("speed block", rx_enable, 32'hb);
      wr_reg(`REG_CONTROL, 32'h0);
      settle(4);
      check("speed pass", rx_enable, 32'hf);
      wr_reg(`REG_CONTROL, 32'h1);
      @(posedge mclk);
      other_speed <= 4'h0;
      for (int i = 0; i < 5; i++) rx_event(4'h1, 16'hc, i != 2, 1'b1);
      check("count cleared", isolated, 32'h0);
      for (int i = 0; i < 3; i++) rx_event(4'h2, 16'hc, 1'b1, i < 2);
      check("count isolate", isolated, 32'h2);
      settle(45);
      rx_event(4'h2, 16'h28, 1'b0, 1'b0);
      check("valid exit", isolated, 32'h0);
      rx_event(4'h4, 16'hc8, 1'b1, 1'b1);
      check("long false", isolated, 32'h4);
      settle(100);
      check("quiet exit 2", isolated, 32'h0);
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         r = $random(seed);
         core_collision <= r[4];
         source_port <= {1'b0, r[6:5]};
         data_sent <= r[7];
         rx_event(r[3:0] | {3'h0, r[4]}, {11'h0, r[12:8]} + 16'ha, 1'b0, 1'b1);
         @(posedge mclk);
         core_collision <= 1'b0;
         settle(4);
      end
      launch(4'h8, 16'h14a, 1'b0);
      settle(310);
      check("jabber", {jabber, rx_enable[3], tx_enable[3]}, 32'h20);
      settle(30);
      check("jabber clear", {jabber, rx_enable[3], tx_enable[3]}, 32'h3);
      xmit(61, 1'b1);
      xmit(1, 1'b0);
      xmit(61, 1'b1);
      settle(4);
      check("no partition", partitioned, 32'h0);
      xmit(1, 1'b1);
      settle(4);
      check("partition", {partitioned, rx_enable[0], tx_enable[0]}, 32'h5);
      rx_event(4'h1, 16'hdc, 1'b0, 1'b0);
      check("partition clear", partitioned, 32'h0);
      stop_test();
   end
endmodule
bind repeater_port_protection port_protection_props #(.N(N)) i_port_protection_props (.mclk(mclk),
   .rstn(rstn), .rd(rd), .rdata(rdata), .carrier(carrier), .rx_enable(rx_enable), .tx_enable(tx_enable),
   .isolated(isolated), .partitioned(partitioned), .jabber(jabber), .force_jam(force_jam),
   .activity_level(activity_level), .jam_request(jam_request));
`default_nettype wire
